// *** rtl/cfg_port_map.vh ***
// Constants for the configuration port decoder: port addresses, keys,
// configuration register indexes and reset values.
// Assumes it is included by bare name from the decoder module file.
`ifndef CFG_PORT_MAP_VH
`define CFG_PORT_MAP_VH

// Power-up configuration port address for each strap level.
`define CFG_BASE_STRAP_LOW   16'h002e
`define CFG_BASE_STRAP_HIGH  16'h004e
// Distance from index port to data port.
`define CFG_DATA_PORT_OFS    16'h0001

// Keys written to the configuration port.
`define CFG_KEY_ENTER        8'h55
`define CFG_KEY_EXIT         8'haa

// Global configuration register indexes.
`define CFG_IDX_CTRL         8'h02
`define CFG_IDX_LDN          8'h07
`define CFG_IDX_DEV_ID       8'h20
`define CFG_IDX_DEV_REV      8'h21
`define CFG_IDX_BASE_LO      8'h26
`define CFG_IDX_BASE_HI      8'h27
// Per logical device register index.
`define CFG_IDX_ACTIVATE     8'h30

// Field positions.
`define CFG_CTRL_SOFT_RST    0
`define CFG_ACTIVATE_BIT     0

// Reset and fixed values.
`define CFG_LDN_RST          8'h00
`define CFG_INDEX_RST        8'h00
`define CFG_DEV_REV          8'h00
`define CFG_BYTE_ZERO        8'h00
`define CFG_BYTE_ONES        8'hff

// Cycles after power-on release before the synchronised strap is caught.
`define CFG_POR_STRAP_WAIT   2'd3
`define CFG_POR_CNT_ZERO     2'd0
`define CFG_POR_CNT_STEP     2'd1

`endif

// *** rtl/config_port_unlock_decoder.v ***
// Primary configuration address decoder: key-unlocked index/data window
// at a strap-selected, software-relocatable I/O address.
// Assumes an I/O cycle front end on mclk that presents one-cycle read and
// write strobes with address and data; strap and host bus reset are pins.
//
// What this block does
// - After host bus reset or power-on reset the block is in run state with every device off.
// - Index writes and data port accesses act only in configuration state; in run state a write to the port address is claimed and checked only for the entry key.
// - The strap is sampled when host bus reset falls and at power-on reset and then held.
// - A low strap puts the configuration port at 0x02E and a high strap at 0x04E.
// - Software may move the port by writing the low and high base byte registers.
// - Writing 0x55 to the configuration port enters configuration state.
// - Writing 0xAA to the configuration port returns to run state.
// - In configuration state the index port sits at the port address and data at the next one.
// - Index 0x07 selects the logical device whose registers the data port then reaches.
`timescale 1ns/10ps
`include "cfg_port_map.vh"

module config_port_unlock_decoder #(
  parameter            NUM_LD    = 11,     // Number of logical devices.
  parameter [7:0]      DEVICE_ID = 8'ha5   // Arbitrary identification value.
) (
  input  wire          mclk,              // Clock, 125 MHz.
  input  wire          rst_b,             // Power-on reset, async, active low.
  input  wire          host_bus_reset_n,  // Host bus reset pin, active low.
  input  wire          addr_strap,        // Address-select strap pin.
  input  wire          io_wr_stb,         // One-cycle host I/O write strobe.
  input  wire          io_rd_stb,         // One-cycle host I/O read strobe.
  input  wire [15:0]   io_addr,           // Host I/O address.
  input  wire [7:0]    io_wdata,          // Host I/O write data.
  output reg  [7:0]    io_rdata_q,        // Read data.
  output reg           io_rvalid_q,       // Read data valid pulse.
  output reg           io_claim_q,        // Access was decoded here.
  output reg           cfg_mode_q,        // High in configuration state.
  output wire [NUM_LD-1:0] ld_active,     // Per logical device activate.
  output reg  [7:0]    ldn_q,             // Selected logical device number.
  output reg  [15:0]   base_q,            // Current configuration port address.
  output reg           ext_wr_q,          // Write pulse to other registers.
  output reg  [7:0]    ext_index_q,       // Index of that write.
  output reg  [7:0]    ext_wdata_q,       // Data of that write.
  output wire [7:0]    cfg_index,         // Current index, for external reads.
  input  wire [7:0]    ext_rdata          // Read data of other registers.
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and reset events.

  reg                  hbr_s1_q;
  reg                  hbr_s2_q;
  reg                  hbr_s3_q;
  reg                  strap_s1_q;
  reg                  strap_s2_q;
  reg  [1:0]           por_cnt_q;
  reg                  por_done_q;
  reg  [7:0]           index_q;
  reg  [NUM_LD-1:0]    act_q;

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hbr_s1_q   <= 1'b1;
      hbr_s2_q   <= 1'b1;
      hbr_s3_q   <= 1'b1;
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
    end else begin
      hbr_s1_q   <= host_bus_reset_n;
      hbr_s2_q   <= hbr_s1_q;
      hbr_s3_q   <= hbr_s2_q;
      strap_s1_q <= addr_strap;
      strap_s2_q <= strap_s1_q;
    end
  end

  wire                 hard_rst = ~hbr_s2_q;
  wire                 hbr_fall = hbr_s3_q & ~hbr_s2_q;

  // Power-up address chosen by the live synchronised strap.
  wire [15:0]          strap_base = strap_s2_q ? `CFG_BASE_STRAP_HIGH :
                                                 `CFG_BASE_STRAP_LOW;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  wire [15:0]          data_addr = base_q + `CFG_DATA_PORT_OFS;
  wire                 cfg_hit   = (io_addr == base_q);
  wire                 data_hit  = (io_addr == data_addr);
  wire                 live      = por_done_q & ~hard_rst;

  // Index and data accesses only count in configuration state.
  wire                 idx_rd    = live & io_rd_stb & cfg_mode_q & cfg_hit;
  wire                 data_rd   = live & io_rd_stb & cfg_mode_q & data_hit;
  wire                 port_wr   = live & io_wr_stb & cfg_hit;
  wire                 data_wr   = live & io_wr_stb & cfg_mode_q & data_hit
                                   & ~cfg_hit;
  wire                 soft_rst  = data_wr & (index_q == `CFG_IDX_CTRL)
                                   & io_wdata[`CFG_CTRL_SOFT_RST];

  assign cfg_index = index_q;

  ////////////////////////////////////////////////////////////////////////////
  // Activate bits, one per logical device.

  genvar               g;
  generate
    for (g = 0; g < NUM_LD; g = g + 1) begin : g_act
      wire act_we = data_wr & (index_q == `CFG_IDX_ACTIVATE) & (ldn_q == g);
      always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          act_q[g] <= 1'b0;
        end else if (hard_rst || soft_rst) begin
          act_q[g] <= 1'b0;
        end else if (act_we) begin
          act_q[g] <= io_wdata[`CFG_ACTIVATE_BIT];
        end
      end
    end
  endgenerate

  assign ld_active = act_q;

  wire                 ldn_ok  = (ldn_q < NUM_LD);
  wire                 act_sel = ldn_ok ? act_q[ldn_q[3:0]] : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux for the data port.

  reg  [7:0]           reg_rd;

  always @* begin
    case (index_q)
      `CFG_IDX_LDN:      reg_rd = ldn_q;
      `CFG_IDX_DEV_ID:   reg_rd = DEVICE_ID;
      `CFG_IDX_DEV_REV:  reg_rd = `CFG_DEV_REV;
      `CFG_IDX_BASE_LO:  reg_rd = base_q[7:0];
      `CFG_IDX_BASE_HI:  reg_rd = base_q[15:8];
      `CFG_IDX_ACTIVATE: reg_rd = {7'h00, act_sel};
      `CFG_IDX_CTRL:     reg_rd = `CFG_BYTE_ZERO;
      default:           reg_rd = ext_rdata;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture, state machine and register writes.

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      por_cnt_q   <= `CFG_POR_CNT_ZERO;
      por_done_q  <= 1'b0;
      base_q      <= `CFG_BASE_STRAP_LOW;
      cfg_mode_q  <= 1'b0;
      index_q     <= `CFG_INDEX_RST;
      ldn_q       <= `CFG_LDN_RST;
      io_rdata_q  <= `CFG_BYTE_ZERO;
      io_rvalid_q <= 1'b0;
      io_claim_q  <= 1'b0;
      ext_wr_q    <= 1'b0;
      ext_index_q <= `CFG_INDEX_RST;
      ext_wdata_q <= `CFG_BYTE_ZERO;
    end else begin
      io_rvalid_q <= 1'b0;
      io_claim_q  <= 1'b0;
      ext_wr_q    <= 1'b0;
      // Wait out the synchroniser, then catch the strap once.
      if (!por_done_q) begin
        if (por_cnt_q == `CFG_POR_STRAP_WAIT) begin
          por_done_q <= 1'b1;
          base_q     <= strap_base;
        end else begin
          por_cnt_q  <= por_cnt_q + `CFG_POR_CNT_STEP;
        end
      end else if (hbr_fall) begin
        // The reloaded base is the only copy of the strap that is kept.
        base_q  <= strap_base;
      end
      if (hard_rst) begin
        cfg_mode_q <= 1'b0;
        index_q    <= `CFG_INDEX_RST;
        ldn_q      <= `CFG_LDN_RST;
      end else if (port_wr) begin
        io_claim_q <= 1'b1;
        if (!cfg_mode_q) begin
          if (io_wdata == `CFG_KEY_ENTER) begin
            cfg_mode_q <= 1'b1;
          end
        end else if (io_wdata == `CFG_KEY_EXIT) begin
          cfg_mode_q <= 1'b0;
        end else begin
          index_q <= io_wdata;
        end
      end else if (data_wr) begin
        io_claim_q <= 1'b1;
        case (index_q)
          `CFG_IDX_LDN:      ldn_q <= io_wdata;
          `CFG_IDX_BASE_LO:  base_q[7:0] <= io_wdata;
          `CFG_IDX_BASE_HI:  base_q[15:8] <= io_wdata;
          `CFG_IDX_CTRL: begin
            if (io_wdata[`CFG_CTRL_SOFT_RST]) begin
              ldn_q <= `CFG_LDN_RST;
            end
          end
          `CFG_IDX_DEV_ID,
          `CFG_IDX_DEV_REV,
          `CFG_IDX_ACTIVATE: begin
            ext_wr_q <= 1'b0;
          end
          default: begin
            ext_wr_q    <= 1'b1;
            ext_index_q <= index_q;
            ext_wdata_q <= io_wdata;
          end
        endcase
      end else if (idx_rd || data_rd) begin
        io_claim_q  <= 1'b1;
        io_rvalid_q <= 1'b1;
        io_rdata_q  <= idx_rd ? index_q : reg_rd;
      end
    end
  end

endmodule // config_port_unlock_decoder

// *** bench/cfg_host_model.sv ***
// Host side model: issues one I/O read or write strobe per call.
// Assumes the decoder answers within three cycles of the strobe.
`timescale 1ns/10ps
module cfg_host_model (
  input  wire         mclk,        // Clock.
  output logic        io_wr_stb,   // Write strobe.
  output logic        io_rd_stb,   // Read strobe.
  output logic [15:0] io_addr,     // Address.
  output logic [7:0]  io_wdata,    // Write data.
  input  wire         io_claim_q,  // Decoded here.
  input  wire         io_rvalid_q, // Read answer.
  input  wire  [7:0]  io_rdata_q   // Read data.
);
  initial begin
    io_wr_stb = 1'b0;
    io_rd_stb = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
  end
  // Released address and data lines show the inverse so stale values are never mistaken for fresh ones.
  task automatic xfer(input logic rd, input logic [15:0] a, input logic [7:0] d,
                      output logic cl, output logic [7:0] rv);
    cl = 1'b0;
    rv = 8'h00;
    @(negedge mclk);
    io_rd_stb = rd;
    io_wr_stb = ~rd;
    io_addr = a;
    io_wdata = d;
    repeat (3) begin
      @(negedge mclk);
      io_rd_stb = 1'b0;
      io_wr_stb = 1'b0;
      io_addr = ~a;
      io_wdata = ~d;
      if (io_claim_q === 1'b1) cl = 1'b1;
      if (io_rvalid_q === 1'b1) rv = io_rdata_q;
    end
  endtask
  task automatic key(input logic [15:0] a, input logic [7:0] k);
    logic       cl;
    logic [7:0] rv;
    xfer(1'b0, a, k, cl, rv);
  endtask
endmodule // cfg_host_model

// *** bench/cfg_decoder_asserts.sv ***
// Checker for the configuration port decoder, bound to its top ports.
// Assumes host accesses are at least three cycles apart.
`timescale 1ns/10ps
module cfg_decoder_asserts #(
  parameter NUM_LD = 11
) (
  input wire              mclk,             // Clock.
  input wire              rst_b,            // Power-on reset, active low.
  input wire              host_bus_reset_n, // Host bus reset pin.
  input wire              addr_strap,       // Address strap pin.
  input wire              io_wr_stb,        // Write strobe.
  input wire              io_rd_stb,        // Read strobe.
  input wire [15:0]       io_addr,          // Address.
  input wire [7:0]        io_wdata,         // Write data.
  input wire              io_claim_q,       // Decoded here.
  input wire              io_rvalid_q,      // Read answer.
  input wire              cfg_mode_q,       // Configuration state.
  input wire [NUM_LD-1:0] ld_active,        // Activate bits.
  input wire [7:0]        ldn_q,            // Logical device number.
  input wire [15:0]       base_q,           // Port address.
  input wire [7:0]        cfg_index         // Current index.
);
  wire [15:0] dport = base_q + 16'h0001;
  wire        wr_cp = io_wr_stb && io_addr == base_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_por_run: assert property ($rose(rst_b) |-> !cfg_mode_q && ld_active == '0)
    else $error("power-on state wrong");
  a_enter_key: assert property (!cfg_mode_q && wr_cp && io_wdata == 8'h55 |-> ##[1:2] cfg_mode_q)
    else $error("entry key ignored");
  a_exit_key: assert property (cfg_mode_q && wr_cp && io_wdata == 8'haa |-> ##[1:2] !cfg_mode_q)
    else $error("exit key ignored");
  a_run_data: assert property (!cfg_mode_q && io_addr == dport && (io_wr_stb || io_rd_stb)
    |=> !io_claim_q ##1 !io_claim_q) else $error("data port live in run");
  a_host_rst: assert property ($fell(host_bus_reset_n) |-> ##4 !cfg_mode_q && ldn_q == 8'h00
    && ld_active == '0) else $error("host reset state wrong");
  a_strap_base: assert property ($fell(host_bus_reset_n)
    |-> ##5 base_q == (addr_strap ? 16'h004e : 16'h002e)) else $error("strap base wrong");
  a_index_wr: assert property (cfg_mode_q && wr_cp && io_wdata != 8'haa
    |-> ##2 cfg_index == $past(io_wdata, 2)) else $error("index not written");
  a_data_read: assert property (cfg_mode_q && io_rd_stb && io_addr == dport |-> ##[1:2] io_rvalid_q)
    else $error("data read unanswered");
  a_move_low: assert property (cfg_mode_q && io_wr_stb && io_addr == dport && cfg_index == 8'h26
    |-> ##2 base_q[7:0] == $past(io_wdata, 2)) else $error("base low not moved");
endmodule // cfg_decoder_asserts

// *** bench/config_port_unlock_decoder_tb.sv ***
// Self-checking bench for the configuration port decoder.
// Assumes the host model issues one spaced I/O cycle per call.
`timescale 1ns/10ps
module config_port_unlock_decoder_tb;
  logic        mclk, rst_b, host_bus_reset_n, addr_strap, c;
  logic        io_wr_stb, io_rd_stb, io_claim_q, io_rvalid_q, cfg_mode_q;
  logic [15:0] io_addr, base_q;
  logic [7:0]  io_wdata, io_rdata_q, ldn_q, cfg_index, r;
  logic [10:0] ld_active;
  logic        ext_wr_q;
  logic [7:0]  ext_index_q, ext_wdata_q, ext_rdata;
  int          ext_wr_seen = 0;
  int          errors = 0;
  int          samples_checked = 0;
  // Arbitrary identification value, the same as the decoder's default.
  localparam logic [7:0] dev_id_exp = 8'ha5;
  config_port_unlock_decoder uut (.mclk, .rst_b, .host_bus_reset_n, .addr_strap, .io_wr_stb,
    .io_rd_stb, .io_addr, .io_wdata, .io_rdata_q, .io_rvalid_q, .io_claim_q, .cfg_mode_q,
    .ld_active, .ldn_q, .base_q, .ext_wr_q, .ext_index_q, .ext_wdata_q, .cfg_index,
    .ext_rdata);
  // Counts write pulses handed to registers held outside the decoder.
  always @(negedge mclk) begin
    if (ext_wr_q === 1'b1) ext_wr_seen <= ext_wr_seen + 1;
  end
  cfg_host_model host (.mclk, .io_wr_stb, .io_rd_stb, .io_addr, .io_wdata, .io_claim_q,
    .io_rvalid_q, .io_rdata_q);
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, c, r);
  endtask
  task automatic summarize;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic t_run_ignore;
    chk("base", 16'h002e, base_q);
    wr(16'h002e, 8'haa);
    chk("claim", 16'h0001, {15'h0, c});
    chk("mode", 16'h0000, {15'h0, cfg_mode_q});
    host.xfer(1'b1, 16'h002f, 8'h00, c, r);
    chk("claim", 16'h0000, {15'h0, c});
  endtask
  task automatic t_config;
    host.key(16'h002e, 8'h55);
    chk("mode", 16'h0001, {15'h0, cfg_mode_q});
    wr(16'h002e, 8'h07);
    wr(16'h002f, 8'h03);
    chk("ldn", 16'h0003, {8'h00, ldn_q});
    wr(16'h002e, 8'h30);
    wr(16'h002f, 8'h01);
    chk("active", 16'h0008, {5'h00, ld_active});
    host.xfer(1'b1, 16'h002e, 8'h00, c, r);
    chk("index", 16'h0030, {8'h00, r});
    host.xfer(1'b1, 16'h002f, 8'h00, c, r);
    chk("data", 16'h0001, {8'h00, r});
    host.key(16'h002e, 8'haa);
    chk("mode", 16'h0000, {15'h0, cfg_mode_q});
    wr(16'h002f, 8'h00);
    chk("active", 16'h0008, {5'h00, ld_active});
  endtask
  task automatic t_relocate;
    host.key(16'h002e, 8'h55);
    wr(16'h002e, 8'h26);
    wr(16'h002f, 8'h4e);
    chk("base", 16'h004e, base_q);
    wr(16'h004e, 8'h27);
    wr(16'h004f, 8'h01);
    chk("base", 16'h014e, base_q);
    host.key(16'h014e, 8'haa);
    chk("mode", 16'h0000, {15'h0, cfg_mode_q});
  endtask
  task automatic t_host_reset;
    addr_strap = 1'b1;
    repeat (3) @(negedge mclk);
    host_bus_reset_n = 1'b0;
    repeat (8) @(negedge mclk);
    chk("base", 16'h004e, base_q);
    chk("active", 16'h0000, {5'h00, ld_active});
    host_bus_reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    host.key(16'h004e, 8'h55);
    chk("mode", 16'h0001, {15'h0, cfg_mode_q});
    host.key(16'h004e, 8'haa);
  endtask
  task automatic t_ext_soft;
    host.key(16'h004e, 8'h55);
    wr(16'h004e, 8'h07);
    wr(16'h004f, 8'h05);
    wr(16'h004e, 8'h30);
    wr(16'h004f, 8'h01);
    chk("active", 16'h0020, {5'h00, ld_active});
    wr(16'h004e, 8'h02);
    wr(16'h004f, 8'h01);
    chk("active", 16'h0000, {5'h00, ld_active});
    chk("ldn", 16'h0000, {8'h00, ldn_q});
    wr(16'h004e, 8'hf0);
    wr(16'h004f, 8'h5a);
    chk("ext", 16'hf05a, {ext_index_q, ext_wdata_q});
    chk("ext_wr", 16'h0001, ext_wr_seen[15:0]);
    ext_rdata = 8'h3c;
    host.xfer(1'b1, 16'h004f, 8'h00, c, r);
    chk("ext_rd", 16'h003c, {8'h00, r});
    wr(16'h004e, 8'h20);
    host.xfer(1'b1, 16'h004f, 8'h00, c, r);
    chk("dev_id", {8'h00, dev_id_exp}, {8'h00, r});
    host.key(16'h004e, 8'haa);
    chk("mode", 16'h0000, {15'h0, cfg_mode_q});
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    #20000;
    errors++;
    summarize();
  end
  initial begin
    rst_b = 1'b0;
    host_bus_reset_n = 1'b1;
    addr_strap = 1'b0;
    ext_rdata = 8'h00;
    repeat (4) @(negedge mclk);
    rst_b = 1'b1;
    repeat (8) @(negedge mclk);
    t_run_ignore();
    t_config();
    t_relocate();
    t_host_reset();
    t_ext_soft();
    summarize();
  end
endmodule // config_port_unlock_decoder_tb
bind config_port_unlock_decoder cfg_decoder_asserts #(.NUM_LD(NUM_LD)) u_chk (.mclk, .rst_b,
  .host_bus_reset_n, .addr_strap, .io_wr_stb, .io_rd_stb, .io_addr, .io_wdata, .io_claim_q,
  .io_rvalid_q, .cfg_mode_q, .ld_active, .ldn_q, .base_q, .cfg_index);
